// File: hdl/wcps_top.sv
// Wrap coordinate logic, parameter store and maintenance command trigger
// Function
// - Valid wrap: 1800/range and steps integral
// - Invalid wrap raises info flag, disables wrap
// - Ratio shifts boundary negative from home
// - Offset value shifts coordinates by steps
// - Home outside shifted range raises info
// - Info at power-up or configure becomes alarm
// - Boundary pulse at equal divisions from home
// - Boundary pulse only while wrap enabled
// - Division count 1 to 536870911, default 1
// - Bus writes only change working storage
// - Power-up loads stored parameters, then recomputes
// - Batch store command copies axis parameters
// - Aborted store raises alarm code 41h
// - Data 0 to 1 executes once only
// - Data 2 executes, then reads back 1
// - Position returns to start each wrap range
// - Ratio in 0.01 percent, 0 to 10000
// - Offset value signed 30-bit step count
`timescale 1ns/1ps
`include "wcps_defines.svh"
module wcps_top
	import wcps_pkg::*;
(
	input wire logic CLK_SYS_I,
	input wire logic RESETN_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic STEP_I,
	input wire logic STEP_DIR_I,
	output logic [47:0] WRAP_POS_O,
	output logic DIVISION_BOUNDARY_PULSE_O,
	output logic WRAP_ERROR_ALARM_O,
	output logic NV_REQ_O,
	output logic NV_WE_O,
	output logic [2:0] NV_ADDR_O,
	output logic [31:0] NV_WDATA_O,
	input wire logic [31:0] NV_RDATA_I,
	input wire logic NV_ACK_I,
	input wire logic NV_ABORT_I
);
	logic rst_meta_q, rst_n;
	logic [31:0] par_q [`WCPS_NPARAM];
	logic [31:0] par_d [`WCPS_NPARAM];
	wcps_state_t st_q, st_d;
	logic [2:0] idx_q, idx_d;
	logic [1:0] stage_q, stage_d;
	logic [1:0] maint_q, maint_d;
	logic pend_q, pend_d, boot_q, boot_d, recalc_q, recalc_d;
	logic c1_q, c1_d, c2_q, c2_d;
	logic info_q, info_d, walarm_q, walarm_d, nvalarm_q, nvalarm_d;
	logic ack_q, ack_d, pulse_q, pulse_d;
	logic [31:0] rdat_q, rdat_d;
	wcps_pos_t steps_q, steps_d, ofsr_q, ofsr_d, seg_q, seg_d;
	wcps_pos_t pos_q, pos_d, phase_q, phase_d;
	wcps_pos_t lo, hi, ofs_v;
	logic home_ok, active, wr_en, cfg_exec, dv_start, dv_busy, dv_done;
	wcps_wide_t dv_num, dv_den, dv_quo, dv_rem;

	// Release of the reset is synchronised; assertion stays asynchronous
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	wcps_div #(.W(WCPS_DW)) u_div (
		.clk_i(CLK_SYS_I),
		.rst_n_i(rst_n),
		.start_i(dv_start),
		.num_i(dv_num),
		.den_i(dv_den),
		.busy_o(dv_busy),
		.done_o(dv_done),
		.quo_o(dv_quo),
		.rem_o(dv_rem)
	);

	// Range limits of the working parameters; control and range accept any value
	function automatic logic wr_ok(input logic [2:0] i, input logic [31:0] d);
		logic ok;
		ok = 1'b1;
		case (i)
			`WCPS_IDX_GEAR_A, `WCPS_IDX_GEAR_B: ok = d[31:16] == 16'h0000 && d != 32'h0;
			`WCPS_IDX_RATIO: ok = d <= `WCPS_RATIO_MAX;
			`WCPS_IDX_OFS_VAL: ok = d[31:29] == {3{d[29]}};
			`WCPS_IDX_DIV_CNT: ok = d[31:29] == 3'h0 && d != 32'h0;
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction : wr_ok

	// Shifted coordinate window: ratio part first, then the step offset
	assign ofs_v = 48'(signed'(par_q[`WCPS_IDX_OFS_VAL][29:0]));
	assign lo = ofs_v - ofsr_q;
	assign hi = lo + steps_q;
	assign home_ok = lo <= 48'sh0 && hi > 48'sh0;
	assign active = par_q[`WCPS_IDX_CTRL][0] && c1_q && c2_q && home_ok
		&& st_q != WCPS_LOAD && st_q != WCPS_CALC
		&& !recalc_q;
	assign wr_en = WB_CYC_I && WB_STB_I && !ack_q;

	always_comb begin
		par_d = par_q;
		st_d = st_q;
		idx_d = idx_q;
		stage_d = stage_q;
		maint_d = maint_q;
		pend_d = pend_q;
		boot_d = boot_q;
		// Taken when the recompute starts, so a write during it runs another
		recalc_d = recalc_q && st_q != WCPS_IDLE;
		c1_d = c1_q;
		c2_d = c2_q;
		steps_d = steps_q;
		ofsr_d = ofsr_q;
		seg_d = seg_q;
		pos_d = pos_q;
		phase_d = phase_q;
		walarm_d = walarm_q;
		nvalarm_d = nvalarm_q;
		info_d = par_q[`WCPS_IDX_CTRL][0] && !(c1_q && c2_q && home_ok);
		ack_d = wr_en;
		pulse_d = 1'b0;
		rdat_d = 32'h0;
		cfg_exec = 1'b0;
		dv_start = 1'b0;
		dv_num = '0;
		dv_den = '0;
		NV_REQ_O = 1'b0;
		NV_WE_O = 1'b0;
		// Bus access, taken on the edge that raises acknowledge
		if (wr_en) begin
			if (WB_ADR_I < `WCPS_ADR_MAINT && WB_ADR_I[1:0] == 2'b00) begin
				rdat_d = par_q[WB_ADR_I[4:2]];
				if (WB_WE_I && wr_ok(WB_ADR_I[4:2], WB_DAT_I)) begin
					par_d[WB_ADR_I[4:2]] = WB_DAT_I;
					recalc_d = 1'b1;
				end
			end else begin
				case (WB_ADR_I)
					`WCPS_ADR_MAINT: begin
						rdat_d = {30'h0, maint_q};
						if (WB_WE_I) begin
							case (WB_DAT_I)
								32'h0: maint_d = `WCPS_MAINT_IDLE;
								32'h1: begin
									maint_d = `WCPS_MAINT_EDGE;
									if (maint_q == `WCPS_MAINT_IDLE) begin
										pend_d = 1'b1;
									end
								end
								32'h2: begin
									maint_d = `WCPS_MAINT_AUTO;
									pend_d = 1'b1;
								end
								default: maint_d = maint_q;
							endcase
						end
					end
					`WCPS_ADR_CONFIG: cfg_exec = WB_WE_I && WB_DAT_I[0];
					`WCPS_ADR_STATUS: begin
						rdat_d[`WCPS_ST_INFO] = info_q;
						rdat_d[`WCPS_ST_WALARM] = walarm_q;
						rdat_d[`WCPS_ST_NVALARM] = nvalarm_q;
						rdat_d[`WCPS_ST_ACTIVE] = active;
						rdat_d[`WCPS_ST_BUSY] = st_q != WCPS_IDLE || recalc_q || pend_q;
						if (nvalarm_q) begin
							rdat_d[`WCPS_ST_CODE_LSB+:8] = `WCPS_ALARM_NV;
						end
						if (WB_WE_I && WB_DAT_I[`WCPS_ST_WALARM]) begin
							walarm_d = 1'b0;
						end
						if (WB_WE_I && WB_DAT_I[`WCPS_ST_NVALARM]) begin
							nvalarm_d = 1'b0;
						end
					end
					`WCPS_ADR_STEPS: rdat_d = steps_q[31:0];
					default: rdat_d = 32'h0;
				endcase
			end
		end
		if (cfg_exec) begin
			recalc_d = 1'b1;
			if (info_q) begin
				walarm_d = 1'b1;
			end
		end
		case (st_q)
			WCPS_LOAD: begin
				NV_REQ_O = 1'b1;
				if (NV_ACK_I) begin
					par_d[idx_q] = NV_RDATA_I;
					idx_d = idx_q + 3'h1;
					if (idx_q == 3'(`WCPS_NPARAM - 1)) begin
						idx_d = 3'h0;
						st_d = WCPS_CALC;
						boot_d = 1'b1;
					end
				end
			end
			WCPS_CALC: begin
				dv_start = !dv_busy && !dv_done;
				case (stage_q)
					2'h0: begin
						dv_num = `WCPS_COORD_TENTHS;
						dv_den = WCPS_DW'(par_q[`WCPS_IDX_RANGE]);
					end
					2'h1: begin
						dv_num = WCPS_DW'(par_q[`WCPS_IDX_RANGE])
							* WCPS_DW'(par_q[`WCPS_IDX_GEAR_B][15:0])
							* `WCPS_RES_PER_TENTH;
						dv_den = WCPS_DW'(par_q[`WCPS_IDX_GEAR_A][15:0]);
					end
					2'h2: begin
						dv_num = WCPS_DW'(steps_q) * WCPS_DW'(par_q[`WCPS_IDX_RATIO]);
						dv_den = `WCPS_RATIO_FULL;
					end
					default: begin
						dv_num = WCPS_DW'(steps_q);
						dv_den = WCPS_DW'(par_q[`WCPS_IDX_DIV_CNT]);
					end
				endcase
				if (dv_done) begin
					stage_d = stage_q + 2'h1;
					case (stage_q)
						2'h0: c1_d = dv_rem == '0 && par_q[`WCPS_IDX_RANGE] != 32'h0;
						2'h1: begin
							c2_d = dv_rem == '0;
							steps_d = dv_quo[47:0];
						end
						2'h2: ofsr_d = dv_quo[47:0];
						default: begin
							// A remainder is dropped: every division is seg_q steps and the phase does not realign at the range wrap
							seg_d = dv_quo[47:0];
							st_d = WCPS_IDLE;
							pos_d = 48'sh0;
							phase_d = 48'sh0;
						end
					endcase
				end
			end
			WCPS_IDLE: begin
				if (boot_q) begin
					boot_d = 1'b0;
					if (info_d) begin
						walarm_d = 1'b1;
					end
				end
				if (recalc_q) begin
					st_d = WCPS_CALC;
				end else if (pend_q) begin
					pend_d = 1'b0;
					st_d = WCPS_STORE;
				end
			end
			WCPS_STORE: begin
				NV_REQ_O = 1'b1;
				NV_WE_O = 1'b1;
				if (NV_ABORT_I || NV_ACK_I && idx_q == 3'(`WCPS_NPARAM - 1)) begin
					idx_d = 3'h0;
					st_d = WCPS_IDLE;
					if (maint_q == `WCPS_MAINT_AUTO && maint_d == maint_q) begin
						maint_d = `WCPS_MAINT_EDGE;
					end
				end else if (NV_ACK_I) begin
					idx_d = idx_q + 3'h1;
				end
				if (NV_ABORT_I) begin
					nvalarm_d = 1'b1;
				end
			end
			default: st_d = WCPS_LOAD;
		endcase
		// Stepping within the window; the start point is treated as home
		if (active && STEP_I && st_q == WCPS_IDLE) begin
			if (STEP_DIR_I) begin
				pos_d = pos_q + 48'sh1 == hi ? lo : pos_q + 48'sh1;
				phase_d = phase_q + 48'sh1 == seg_q ? 48'sh0 : phase_q + 48'sh1;
			end else begin
				pos_d = pos_q == lo ? hi - 48'sh1 : pos_q - 48'sh1;
				phase_d = phase_q == 48'sh0 ? seg_q - 48'sh1 : phase_q - 48'sh1;
			end
			pulse_d = phase_d == 48'sh0;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			par_q[`WCPS_IDX_CTRL] <= `WCPS_RST_CTRL;
			par_q[`WCPS_IDX_RANGE] <= `WCPS_RST_RANGE;
			par_q[`WCPS_IDX_GEAR_A] <= `WCPS_RST_GEAR;
			par_q[`WCPS_IDX_GEAR_B] <= `WCPS_RST_GEAR;
			par_q[`WCPS_IDX_RATIO] <= `WCPS_RST_RATIO;
			par_q[`WCPS_IDX_OFS_VAL] <= `WCPS_RST_OFS_VAL;
			par_q[`WCPS_IDX_DIV_CNT] <= `WCPS_RST_DIV_CNT;
			st_q <= WCPS_LOAD;
			idx_q <= 3'h0;
			stage_q <= 2'h0;
			maint_q <= `WCPS_MAINT_IDLE;
			pend_q <= 1'b0;
			boot_q <= 1'b0;
			recalc_q <= 1'b0;
			c1_q <= 1'b0;
			c2_q <= 1'b0;
			info_q <= 1'b0;
			walarm_q <= 1'b0;
			nvalarm_q <= 1'b0;
			ack_q <= 1'b0;
			pulse_q <= 1'b0;
			rdat_q <= 32'h0;
			steps_q <= 48'sh0;
			ofsr_q <= 48'sh0;
			seg_q <= 48'sh0;
			pos_q <= 48'sh0;
			phase_q <= 48'sh0;
		end else begin
			par_q <= par_d;
			st_q <= st_d;
			idx_q <= idx_d;
			stage_q <= stage_d;
			maint_q <= maint_d;
			pend_q <= pend_d;
			boot_q <= boot_d;
			recalc_q <= recalc_d;
			c1_q <= c1_d;
			c2_q <= c2_d;
			info_q <= info_d;
			walarm_q <= walarm_d;
			nvalarm_q <= nvalarm_d;
			ack_q <= ack_d;
			pulse_q <= pulse_d;
			rdat_q <= rdat_d;
			steps_q <= steps_d;
			ofsr_q <= ofsr_d;
			seg_q <= seg_d;
			pos_q <= pos_d;
			phase_q <= phase_d;
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;
	assign WRAP_POS_O = pos_q;
	assign DIVISION_BOUNDARY_PULSE_O = pulse_q;
	assign WRAP_ERROR_ALARM_O = walarm_q;
	assign NV_ADDR_O = idx_q;
	assign NV_WDATA_O = par_q[idx_q];
endmodule : wcps_top

// File: hdl/wcps_defines.svh
// Offsets, field positions, reset values and constants of the wrap block
`ifndef WCPS_DEFINES_SVH
`define WCPS_DEFINES_SVH
`define WCPS_ADR_CTRL 8'h00
`define WCPS_ADR_RANGE 8'h04
`define WCPS_ADR_GEAR_A 8'h08
`define WCPS_ADR_GEAR_B 8'h0c
`define WCPS_ADR_RATIO 8'h10
`define WCPS_ADR_OFS_VAL 8'h14
`define WCPS_ADR_DIV_CNT 8'h18
`define WCPS_ADR_MAINT 8'h1c
`define WCPS_ADR_CONFIG 8'h20
`define WCPS_ADR_STATUS 8'h24
`define WCPS_ADR_STEPS 8'h28
`define WCPS_NPARAM 7
`define WCPS_IDX_CTRL 3'h0
`define WCPS_IDX_RANGE 3'h1
`define WCPS_IDX_GEAR_A 3'h2
`define WCPS_IDX_GEAR_B 3'h3
`define WCPS_IDX_RATIO 3'h4
`define WCPS_IDX_OFS_VAL 3'h5
`define WCPS_IDX_DIV_CNT 3'h6
`define WCPS_RST_CTRL 32'h0000_0001
`define WCPS_RST_RANGE 32'h0000_0064
`define WCPS_RST_GEAR 32'h0000_0001
`define WCPS_RST_RATIO 32'h0000_1388
`define WCPS_RST_OFS_VAL 32'h0000_0000
`define WCPS_RST_DIV_CNT 32'h0000_0001
`define WCPS_COORD_TENTHS 56'h00_0000_0000_4650
`define WCPS_RES_PER_TENTH 56'h00_0000_0000_03e8
`define WCPS_RATIO_FULL 56'h00_0000_0000_2710
`define WCPS_RATIO_MAX 32'h0000_2710
`define WCPS_ALARM_NV 8'h41
`define WCPS_MAINT_IDLE 2'h0
`define WCPS_MAINT_EDGE 2'h1
`define WCPS_MAINT_AUTO 2'h2
`define WCPS_ST_INFO 0
`define WCPS_ST_WALARM 1
`define WCPS_ST_NVALARM 2
`define WCPS_ST_ACTIVE 3
`define WCPS_ST_BUSY 4
`define WCPS_ST_CODE_LSB 8
`endif

// File: hdl/wcps_pkg.sv
// Types shared by the wrap coordinate and parameter store block
package wcps_pkg;
	localparam int WCPS_DW = 56;
	typedef logic [WCPS_DW-1:0] wcps_wide_t;
	typedef logic signed [47:0] wcps_pos_t;
	typedef enum logic [2:0] {
		WCPS_LOAD = 3'b000,
		WCPS_CALC = 3'b001,
		WCPS_IDLE = 3'b011,
		WCPS_STORE = 3'b010
	} wcps_state_t;
endpackage : wcps_pkg

// File: hdl/wcps_div.sv
// Restoring sequential divider, one quotient bit per clock
`timescale 1ns/1ps
module wcps_div #(
	parameter int W = 56
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [W-1:0] num_i,
	input wire logic [W-1:0] den_i,
	output logic busy_o,
	output logic done_o,
	output logic [W-1:0] quo_o,
	output logic [W-1:0] rem_o
);
	logic [W-1:0] quo_q, quo_d, rem_q, rem_d, den_q, den_d;
	logic [6:0] cnt_q, cnt_d;
	logic busy_q, busy_d, done_q, done_d;
	logic [W:0] trial;

	always_comb begin
		quo_d = quo_q;
		rem_d = rem_q;
		den_d = den_q;
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		trial = {rem_q, quo_q[W-1]};
		if (start_i && !busy_q) begin
			quo_d = num_i;
			rem_d = '0;
			den_d = den_i;
			cnt_d = 7'(W);
			busy_d = 1'b1;
		end else if (busy_q) begin
			// Zero divisor yields all ones and leaves the numerator as the remainder
			if (trial >= {1'b0, den_q}) begin
				rem_d = W'(trial - {1'b0, den_q});
				quo_d = {quo_q[W-2:0], 1'b1};
			end else begin
				rem_d = trial[W-1:0];
				quo_d = {quo_q[W-2:0], 1'b0};
			end
			cnt_d = cnt_q - 7'h01;
			if (cnt_q == 7'h01) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quo_q <= '0;
			rem_q <= '0;
			den_q <= '0;
			cnt_q <= 7'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			quo_q <= quo_d;
			rem_q <= rem_d;
			den_q <= den_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;
	assign quo_o = quo_q;
	assign rem_o = rem_q;
endmodule : wcps_div

// File: tb/wcps_nv_model.sv
// Non-volatile parameter image that answers word loads and stores
`timescale 1ns/1ps
module wcps_nv_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [2:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic slow_i,
	input wire logic abort_arm_i,
	output logic [31:0] rdata_o,
	output logic ack_o,
	output logic abort_o,
	output logic [7:0] stores_o
);
	// Image is never reset, so it outlives a power cycle
	logic [31:0] mem [0:6] = '{32'h1, 32'h64, 32'h1, 32'h1, 32'h1388,
		32'h0, 32'h4};
	logic [3:0] wait_q;
	// Word valid only with ack; inverted otherwise to expose late samples
	assign rdata_o = ack_o ? mem[addr_i] : ~mem[addr_i];
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_q <= 4'h0;
			ack_o <= 1'b0;
			abort_o <= 1'b0;
			stores_o <= 8'h00;
		end else begin
			ack_o <= 1'b0;
			abort_o <= 1'b0;
			wait_q <= 4'h0;
			// Latency lets the block leave its own reset first
			if (req_i && !ack_o && !abort_o) begin
				wait_q <= wait_q + 4'h1;
				if (wait_q == (slow_i ? 4'h9 : 4'h3)) begin
					if (we_i && abort_arm_i && addr_i == 3'h3) begin
						abort_o <= 1'b1;
					end else begin
						ack_o <= 1'b1;
						if (we_i) begin
							mem[addr_i] <= wdata_i;
							if (addr_i == 3'h6) stores_o <= stores_o + 8'h01;
						end
					end
				end
			end
		end
	end
endmodule : wcps_nv_model

// File: tb/wcps_top_properties.sv
// Port checker of the wrap coordinate and parameter store block
`timescale 1ns/1ps
module wcps_checker (
	input wire logic CLK_SYS_I,
	input wire logic RESETN_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic STEP_I,
	input wire logic DIVISION_BOUNDARY_PULSE_O,
	input wire logic NV_REQ_O,
	input wire logic NV_WE_O,
	input wire logic [2:0] NV_ADDR_O,
	input wire logic NV_ACK_I,
	input wire logic NV_ABORT_I
);
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RESETN_I);
	property p_boot;
		$rose(RESETN_I) |-> (NV_REQ_O && !NV_WE_O) [*3];
	endproperty
	a_boot: assert property (p_boot)
		else $error("no load after reset");
	property p_next;
		NV_REQ_O && NV_ACK_I && NV_ADDR_O < 3'h6
			|=> NV_ADDR_O == $past(NV_ADDR_O) + 3'h1;
	endproperty
	a_next: assert property (p_next)
		else $error("word order broken");
	property p_first;
		$rose(NV_WE_O) |-> NV_ADDR_O == 3'h0;
	endproperty
	a_first: assert property (p_first)
		else $error("store not from word 0");
	property p_we;
		NV_WE_O |-> NV_REQ_O;
	endproperty
	a_we: assert property (p_we)
		else $error("write without request");
	property p_abort;
		NV_WE_O && NV_ABORT_I |=> !NV_WE_O;
	endproperty
	a_abort: assert property (p_abort)
		else $error("store kept after abort");
	property p_ack;
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus access not answered");
	property p_ack1;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack1: assert property (p_ack1)
		else $error("ack longer than one cycle");
	property p_pulse;
		DIVISION_BOUNDARY_PULSE_O |-> $past(STEP_I);
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("boundary pulse without step");
endmodule : wcps_checker
bind wcps_top wcps_checker u_chk (.CLK_SYS_I(CLK_SYS_I),
	.RESETN_I(RESETN_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_ACK_O(WB_ACK_O), .STEP_I(STEP_I), .NV_REQ_O(NV_REQ_O),
	.DIVISION_BOUNDARY_PULSE_O(DIVISION_BOUNDARY_PULSE_O),
	.NV_WE_O(NV_WE_O), .NV_ADDR_O(NV_ADDR_O), .NV_ACK_I(NV_ACK_I),
	.NV_ABORT_I(NV_ABORT_I));

// File: tb/wcps_top_tb.sv
// Self-checking testbench of the wrap coordinate and parameter store block
`timescale 1ns/1ps
`include "wcps_defines.svh"
module wcps_top_tb;
	localparam logic [31:0] ff = 32'hffff_ffff;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, step = 1'b0, dir = 1'b1;
	logic slow = 1'b0, arm = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat, nv_rd, nv_wd;
	logic ack, nv_req, nv_we, nv_ack, nv_abort, pulse, alarm;
	logic [2:0] nv_addr;
	logic [47:0] pos;
	logic [7:0] stores, s;
	int error_cnt = 0, check_count = 0, pulses = 0, p0;
	always #2.5 clk = ~clk;
	always @(posedge clk) if (pulse === 1'b1) pulses <= pulses + 1;
	wcps_top DUT (.CLK_SYS_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
		.WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .STEP_I(step),
		.STEP_DIR_I(dir), .WRAP_POS_O(pos), .WRAP_ERROR_ALARM_O(alarm),
		.DIVISION_BOUNDARY_PULSE_O(pulse), .NV_REQ_O(nv_req),
		.NV_WE_O(nv_we), .NV_ADDR_O(nv_addr), .NV_WDATA_O(nv_wd),
		.NV_RDATA_I(nv_rd), .NV_ACK_I(nv_ack), .NV_ABORT_I(nv_abort));
	wcps_nv_model u_nv (.clk_i(clk), .rst_n_i(rst_n), .req_i(nv_req),
		.we_i(nv_we), .addr_i(nv_addr), .wdata_i(nv_wd), .slow_i(slow),
		.abort_arm_i(arm), .rdata_o(nv_rd), .ack_o(nv_ack),
		.abort_o(nv_abort), .stores_o(stores));
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [47:0] v, e);
		check_count++;
		if (v !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, v);
		end
	endtask : chk
	// Held until ack is sampled high, released on that same edge
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 40) chk("bus ack", 48'h0, 48'h1);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] m, e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(nm, 48'(q & m), 48'(e));
	endtask : rd
	// Polls until neither a recompute nor a store is running
	task automatic settle();
		logic [31:0] q;
		int n;
		n = 0;
		repeat (8) @(posedge clk);
		do begin
			bus(`WCPS_ADR_STATUS, 1'b0, 32'h0, q);
			n++;
		end while ((q[`WCPS_ST_BUSY] !== 1'b0 || nv_req !== 1'b0) && n < 300);
		if (n >= 300) chk("settle", 48'h0, 48'h1);
	endtask : settle
	task automatic walk(input int n);
		repeat (n) begin
			@(posedge clk);
			step <= 1'b1;
			@(posedge clk);
			step <= 1'b0;
		end
		repeat (2) @(posedge clk);
	endtask : walk
	task automatic boot();
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		settle();
	endtask : boot
	task automatic t_boot();
		rd("div", `WCPS_ADR_DIV_CNT, ff, 32'h4);
		rd("ratio", `WCPS_ADR_RATIO, ff, 32'h1388);
		rd("steps", `WCPS_ADR_STEPS, ff, 32'h186a0);
		rd("unmapped", 8'h3c, ff, 32'h0);
		wr(`WCPS_ADR_DIV_CNT, 32'h0);
		rd("div 0", `WCPS_ADR_DIV_CNT, ff, 32'h4);
		wr(`WCPS_ADR_DIV_CNT, 32'h1fff_ffff);
		wr(`WCPS_ADR_DIV_CNT, 32'h2000_0000);
		rd("div max", `WCPS_ADR_DIV_CNT, ff, 32'h1fff_ffff);
		wr(`WCPS_ADR_RATIO, 32'h2711);
		rd("ratio", `WCPS_ADR_RATIO, ff, 32'h1388);
		wr(`WCPS_ADR_OFS_VAL, 32'he000_0000);
		wr(`WCPS_ADR_OFS_VAL, 32'h2000_0000);
		rd("ofs", `WCPS_ADR_OFS_VAL, ff, 32'he000_0000);
		wr(`WCPS_ADR_OFS_VAL, 32'h0);
		settle();
	endtask : t_boot
	task automatic t_wrap();
		wr(`WCPS_ADR_RANGE, 32'h2710);
		settle();
		rd("info", `WCPS_ADR_STATUS, 32'hb, 32'h1);
		wr(`WCPS_ADR_CONFIG, 32'h1);
		settle();
		chk("alarm", 48'(alarm), 48'h1);
		wr(`WCPS_ADR_RANGE, 32'h64);
		settle();
		wr(`WCPS_ADR_STATUS, 32'h2);
		rd("clear", `WCPS_ADR_STATUS, 32'hb, 32'h8);
		wr(`WCPS_ADR_RATIO, 32'h0);
		wr(`WCPS_ADR_OFS_VAL, 32'h1);
		settle();
		rd("home", `WCPS_ADR_STATUS, 32'h9, 32'h1);
		wr(`WCPS_ADR_OFS_VAL, 32'h0);
		wr(`WCPS_ADR_RATIO, 32'h1388);
	endtask : t_wrap
	// Five steps a range: gear A 1000, range half a revolution
	task automatic t_steps();
		wr(`WCPS_ADR_DIV_CNT, 32'h1);
		wr(`WCPS_ADR_GEAR_A, 32'h3e8);
		wr(`WCPS_ADR_RANGE, 32'h5);
		settle();
		p0 = pulses;
		walk(3);
		chk("pos", pos, 48'hffff_ffff_fffe);
		walk(7);
		chk("pos", pos, 48'h0);
		chk("pulses", 48'(pulses - p0), 48'h2);
		wr(`WCPS_ADR_OFS_VAL, 32'h1);
		wr(`WCPS_ADR_DIV_CNT, 32'h5);
		settle();
		p0 = pulses;
		walk(3);
		chk("pos", pos, 48'h3);
		walk(7);
		chk("pulses", 48'(pulses - p0), 48'ha);
		// Reverse steps from 0 pass the low end and wrap to hi - 1
		dir <= 1'b0;
		walk(2);
		chk("pos back", pos, 48'h3);
		dir <= 1'b1;
		wr(`WCPS_ADR_CTRL, 32'h0);
		settle();
		p0 = pulses;
		walk(10);
		chk("pulses", 48'(pulses - p0), 48'h0);
	endtask : t_steps
	task automatic t_maint();
		s = stores;
		wr(`WCPS_ADR_MAINT, 32'h1);
		settle();
		wr(`WCPS_ADR_MAINT, 32'h1);
		settle();
		chk("stores", 48'(stores - s), 48'h1);
		wr(`WCPS_ADR_MAINT, 32'h0);
		wr(`WCPS_ADR_MAINT, 32'h1);
		wr(`WCPS_ADR_MAINT, 32'h3);
		settle();
		chk("stores", 48'(stores - s), 48'h2);
		rd("data", `WCPS_ADR_MAINT, ff, 32'h1);
		slow <= 1'b1;
		wr(`WCPS_ADR_MAINT, 32'h2);
		settle();
		rd("data", `WCPS_ADR_MAINT, ff, 32'h1);
		wr(`WCPS_ADR_MAINT, 32'h2);
		settle();
		chk("stores", 48'(stores - s), 48'h4);
		chk("image", 48'(u_nv.mem[6]), 48'h5);
		slow <= 1'b0;
		arm <= 1'b1;
		wr(`WCPS_ADR_MAINT, 32'h2);
		settle();
		rd("nv alarm", `WCPS_ADR_STATUS, 32'hff04, 32'h4104);
		arm <= 1'b0;
		wr(`WCPS_ADR_STATUS, 32'h4);
		rd("nv clear", `WCPS_ADR_STATUS, 32'h4, 32'h0);
		// Unstored change must not survive a power cycle
		wr(`WCPS_ADR_RATIO, 32'h1b58);
		boot();
		rd("ratio", `WCPS_ADR_RATIO, ff, 32'h1388);
		rd("div", `WCPS_ADR_DIV_CNT, ff, 32'h5);
	endtask : t_maint
	initial begin
		boot();
		t_boot();
		t_wrap();
		t_steps();
		t_maint();
		final_report();
	end
	initial begin
		#300000;
		error_cnt++;
		final_report();
	end
endmodule : wcps_top_tb
